// *** hw/tms_consts.vh ***
// constants for the transmit test-mode symbol generator
// assumes 32-bit AXI4-Lite register access, byte addresses
`ifndef TMS_CONSTS_VH
`define TMS_CONSTS_VH
// register byte offsets
`define TMS_CTRL_OFS      4'h0
`define TMS_STAT_OFS      4'h4
`define TMS_SCR_OFS       4'h8
// control fields
`define TMS_MODE_HI       15
`define TMS_MODE_LO       13
`define TMS_CLKOE_BIT     0
`define TMS_CTRL_RST      32'h00000000
// test mode codes
`define TMS_MODE_NORM     3'h0
`define TMS_MODE_1        3'h1
`define TMS_MODE_2        3'h2
`define TMS_MODE_3        3'h3
`define TMS_MODE_4        3'h4
// symbol widths and pattern
`define TMS_SYM_W         3
`define TMS_PAT_LEN       16
`define TMS_PAT_IDX_W     4
// scrambler
`define TMS_SCR_W         11
`define TMS_SCR_RST       11'h7FF
// quinary levels, two's complement
`define TMS_SYM_P2        3'h2
`define TMS_SYM_P1        3'h1
`define TMS_SYM_Z         3'h0
`define TMS_SYM_M1        3'h7
`define TMS_SYM_M2        3'h6
// bus responses
`define TMS_RESP_OK       2'h0
`define TMS_RESP_ERR      2'h2
`endif

// *** hw/tms_symbol_gen.v ***
// transmit test-mode symbol generator with AXI4-Lite control
// symbol ticks come from the local and recovered timing logic
// on ref_clk; the line transmitters take the four symbol outputs
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "tms_consts.vh"

module tms_symbol_gen
#(
  parameter [47:0] PAT1 = 48'h1F80F85A5247,
  parameter [10:0] POLY = 11'h500
)
(
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [2:0]  strap_test_mode,
  input  wire        cfg_leader,
  input  wire        local_sym_tick,
  input  wire        recov_sym_tick,
  input  wire [2:0]  norm_sym_a,
  input  wire [2:0]  norm_sym_b,
  input  wire [2:0]  norm_sym_c,
  input  wire [2:0]  norm_sym_d,
  output reg  [2:0]  tx_sym_a,
  output reg  [2:0]  tx_sym_b,
  output reg  [2:0]  tx_sym_c,
  output reg  [2:0]  tx_sym_d,
  output reg         tx_sym_valid,
  output reg         timing_leader,
  output reg         tx_symbol_clock
);

  // ==========================================================
  // helpers
  function [2:0] map_sym;
    input [2:0] b;
    begin
      case (b)
        3'h0:    map_sym = `TMS_SYM_Z;
        3'h1:    map_sym = `TMS_SYM_P1;
        3'h2:    map_sym = `TMS_SYM_P2;
        3'h3:    map_sym = `TMS_SYM_M1;
        3'h4:    map_sym = `TMS_SYM_M2;
        default: map_sym = `TMS_SYM_Z;
      endcase
    end
  endfunction

  function [2:0] legal_mode;
    input [2:0] m;
    begin
      // codes above 4 are reserved and act as normal
      legal_mode = (m > `TMS_MODE_4) ? `TMS_MODE_NORM : m;
    end
  endfunction

  // ==========================================================
  // register bus
  reg  [31:0] ctrl_reg;
  reg  [3:0]  aw_addr_reg;
  reg         aw_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_held_reg;
  reg  [31:0] ctrl_next;
  reg  [31:0] rd_val;
  reg  [1:0]  rd_resp;
  wire        wr_go;
  integer     i;

  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go         = aw_held_reg & w_held_reg;

  always @*
  begin
    ctrl_next = ctrl_reg;
    for (i = 0; i < 4; i = i + 1)
      if (w_strb_reg[i])
        ctrl_next[i*8 +: 8] = w_data_reg[i*8 +: 8];
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_addr_reg  <= 4'h0;
      aw_held_reg  <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      w_held_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TMS_RESP_OK;
      ctrl_reg     <= `TMS_CTRL_RST;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
      end
      if (wr_go)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == `TMS_CTRL_OFS)
        begin
          ctrl_reg    <= ctrl_next;
          s_axi_bresp <= `TMS_RESP_OK;
        end
        else if (aw_addr_reg == `TMS_STAT_OFS ||
                 aw_addr_reg == `TMS_SCR_OFS)
          s_axi_bresp <= `TMS_RESP_OK;
        else
          s_axi_bresp <= `TMS_RESP_ERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // mode selection
  reg  [2:0]  strap_s1_reg;
  reg  [2:0]  strap_s2_reg;
  reg  [2:0]  strap_s3_reg;
  reg  [2:0]  strap_reg;
  wire [2:0]  reg_mode;
  wire [2:0]  act_mode;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_s1_reg <= 3'h0;
      strap_s2_reg <= 3'h0;
      strap_s3_reg <= 3'h0;
      strap_reg    <= 3'h0;
    end
    else
    begin
      strap_s1_reg <= strap_test_mode;
      strap_s2_reg <= strap_s1_reg;
      strap_s3_reg <= strap_s2_reg;
      if (strap_s2_reg == strap_s3_reg)
        strap_reg <= strap_s3_reg;
    end
  end

  // reserved codes fall back to normal
  assign reg_mode = legal_mode(ctrl_reg[`TMS_MODE_HI:`TMS_MODE_LO]);
  // register wins, strap used when it is zero
  assign act_mode = (reg_mode != `TMS_MODE_NORM) ? reg_mode :
                    legal_mode(strap_reg);

  // ==========================================================
  // symbol timing
  reg         lead_sel;
  wire        tick;

  always @*
  begin
    case (act_mode)
      `TMS_MODE_1: lead_sel = 1'b1;
      `TMS_MODE_2: lead_sel = 1'b1;
      `TMS_MODE_4: lead_sel = 1'b1;
      `TMS_MODE_3: lead_sel = 1'b0;
      default:     lead_sel = cfg_leader;
    endcase
  end

  assign tick = lead_sel ? local_sym_tick : recov_sym_tick;

  // ==========================================================
  // pattern generators
  reg  [3:0]  pat_idx_reg;
  reg         alt_reg;
  reg  [10:0] scr_reg;
  wire        scr_fb;
  wire        dbit0;
  wire        dbit1;
  wire        dbit2;
  wire [2:0]  pat_sym;

  assign scr_fb = ^(scr_reg & POLY);
  assign dbit0  = scr_reg[0];
  assign dbit1  = scr_reg[1] ^ scr_reg[4];
  assign dbit2  = scr_reg[2] ^ scr_reg[8];
  assign pat_sym = PAT1[pat_idx_reg*3 +: 3];

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pat_idx_reg <= 4'h0;
      alt_reg     <= 1'b0;
      scr_reg     <= `TMS_SCR_RST;
    end
    else if (tick)
    begin
      if (act_mode == `TMS_MODE_1)
        pat_idx_reg <= pat_idx_reg + 4'h1;
      else
        pat_idx_reg <= 4'h0;
      alt_reg <= ~alt_reg;
      if (act_mode == `TMS_MODE_4)
        scr_reg <= {scr_reg[9:0], scr_fb};
    end
  end

  // ==========================================================
  // symbol output
  reg  [2:0]  t_sym;

  always @*
  begin
    case (act_mode)
      `TMS_MODE_1: t_sym = pat_sym;
      `TMS_MODE_2: t_sym = alt_reg ? `TMS_SYM_M2 : `TMS_SYM_P2;
      `TMS_MODE_3: t_sym = alt_reg ? `TMS_SYM_M2 : `TMS_SYM_P2;
      `TMS_MODE_4: t_sym = map_sym({dbit2, dbit1, dbit0});
      default:     t_sym = `TMS_SYM_Z;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_sym_a        <= `TMS_SYM_Z;
      tx_sym_b        <= `TMS_SYM_Z;
      tx_sym_c        <= `TMS_SYM_Z;
      tx_sym_d        <= `TMS_SYM_Z;
      tx_sym_valid    <= 1'b0;
      timing_leader   <= 1'b0;
      tx_symbol_clock <= 1'b0;
    end
    else
    begin
      tx_sym_valid  <= tick;
      timing_leader <= lead_sel;
      if (!ctrl_reg[`TMS_CLKOE_BIT])
        tx_symbol_clock <= 1'b0;
      else if (tick)
        tx_symbol_clock <= ~tx_symbol_clock;
      if (tick)
      begin
        if (act_mode == `TMS_MODE_NORM)
        begin
          tx_sym_a <= norm_sym_a;
          tx_sym_b <= norm_sym_b;
          tx_sym_c <= norm_sym_c;
          tx_sym_d <= norm_sym_d;
        end
        else
        begin
          tx_sym_a <= t_sym;
          tx_sym_b <= t_sym;
          tx_sym_c <= t_sym;
          tx_sym_d <= t_sym;
        end
      end
    end
  end

  // ==========================================================
  // register reads
  always @*
  begin
    rd_val  = 32'h00000000;
    rd_resp = `TMS_RESP_OK;
    case (s_axi_araddr)
      `TMS_CTRL_OFS: rd_val = ctrl_reg;
      `TMS_STAT_OFS: rd_val = {24'h000000, timing_leader,
                               1'b0, strap_reg, act_mode};
      `TMS_SCR_OFS:  rd_val = {21'h000000, scr_reg};
      default:       rd_resp = `TMS_RESP_ERR;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `TMS_RESP_OK;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_resp;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// *** tb/tms_tick_src.sv ***
// symbol tick sources seen from the line side
// runs on the bench ref_clk, same reset as the design
`timescale 1ns/10ps
module tms_tick_src
(
  input  wire ref_clk,
  input  wire rst_n,
  output wire local_sym_tick,
  output wire recov_sym_tick
);
  reg [2:0] cnt_reg;
  wire [2:0] cnt_next = (cnt_reg == 3'h5) ? 3'h0 : cnt_reg + 3'h1;
  // ==========================================
  // tick phase counter
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= 3'h0;
    else
      cnt_reg <= cnt_next;
  end
  assign local_sym_tick = ~cnt_reg[0];
  assign recov_sym_tick = (cnt_reg == 3'h0) || (cnt_reg == 3'h3);
endmodule

// *** tb/tms_symbol_gen_assertions.sv ***
// port checker for tms_symbol_gen
// bound from the bench top file
`timescale 1ns/10ps
module tms_symbol_gen_assertions
(
  input wire       ref_clk,
  input wire       rst_n,
  input wire       s_axi_awready,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire [1:0] s_axi_rresp,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  input wire       local_sym_tick,
  input wire       recov_sym_tick,
  input wire [2:0] tx_sym_a,
  input wire [2:0] tx_sym_b,
  input wire [2:0] tx_sym_c,
  input wire [2:0] tx_sym_d,
  input wire       tx_sym_valid,
  input wire       timing_leader,
  input wire       tx_symbol_clock
);
  // ==========================================
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_TICK_SRC: assert property (
    tx_sym_valid |-> (timing_leader ? $past(local_sym_tick)
    : $past(recov_sym_tick))) else $error("symbol from wrong tick");
  AST_CLK_RISE: assert property (
    $rose(tx_symbol_clock) |-> tx_sym_valid) else $error("clock edge");
  AST_SYM_HOLD: assert property (
    !tx_sym_valid |-> $stable({tx_sym_a, tx_sym_b, tx_sym_c, tx_sym_d}))
    else $error("symbol moved");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b drop");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("r drop");
  AST_AR_RDY: assert property (
    s_axi_arready != s_axi_rvalid) else $error("arready wrong");
  AST_RD_ANS: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no r");
  AST_AW_BLOCK: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw");
endmodule

// *** tb/tms_symbol_gen_tb.sv ***
// self-checking bench for tms_symbol_gen
// AXI4-Lite master tasks; ticks from tms_tick_src
`timescale 1ns/10ps
`include "tms_consts.vh"
module tms_symbol_gen_tb;
  localparam [47:0] PAT = 48'h0A4C31E297B5;
  reg         ref_clk, rst_n, cfg_leader, hs, ar, aw, wd, q;
  reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  reg  [31:0] s_axi_wdata, rv;
  reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready;
  reg  [2:0]  strap_test_mode;
  reg  [1:0]  rr, br;
  reg  [10:0] sm;
  reg  [2:0]  e3;
  integer     fail_count, checks, i;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, local_sym_tick, recov_sym_tick;
  wire        tx_sym_valid, timing_leader, tx_symbol_clock;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [2:0]  tx_sym_a, tx_sym_b, tx_sym_c, tx_sym_d;
  wire [11:0] s4 = {tx_sym_a, tx_sym_b, tx_sym_c, tx_sym_d};

  tms_symbol_gen #(.PAT1(PAT)) i_tms_symbol_gen
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .strap_test_mode(strap_test_mode), .cfg_leader(cfg_leader),
    .local_sym_tick(local_sym_tick), .recov_sym_tick(recov_sym_tick),
    .norm_sym_a(3'h1), .norm_sym_b(3'h2), .norm_sym_c(3'h7),
    .norm_sym_d(3'h6), .tx_sym_a(tx_sym_a), .tx_sym_b(tx_sym_b),
    .tx_sym_c(tx_sym_c), .tx_sym_d(tx_sym_d), .tx_sym_valid(tx_sym_valid),
    .timing_leader(timing_leader), .tx_symbol_clock(tx_symbol_clock)
  );
  tms_tick_src i_tms_tick_src
  (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .local_sym_tick(local_sym_tick), .recov_sym_tick(recov_sym_tick)
  );

  // ==========================================
  // tasks
  task chk(input [31:0] g, input [31:0] e);
  begin
    checks = checks + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  task wr(input [3:0] a, input [31:0] d);
  begin
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    hs = 1'h0;
    while (!hs)
    begin
      @(negedge ref_clk);
      hs = s_axi_bvalid;
      br = s_axi_bresp;
      aw = s_axi_awready;
      wd = s_axi_wready;
      @(posedge ref_clk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (wd) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  end
  endtask
  task rd(input [3:0] a);
  begin
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    hs = 1'h0;
    while (!hs)
    begin
      @(negedge ref_clk);
      hs = s_axi_rvalid;
      ar = s_axi_arready;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge ref_clk);
      if (ar) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  end
  endtask
  // waits for the next symbol pulse, bounded
  task sy(input f);
  begin
    if (!f) @(posedge ref_clk);
    #1;
    repeat (9) if (tx_sym_valid !== 1'h1) @(posedge ref_clk) #1;
  end
  endtask
  task alt(input ld);
  reg [2:0] p;
  begin
    sy(1'h0);
    sy(1'h0);
    repeat (4)
    begin
      p = (tx_sym_a === `TMS_SYM_P2) ? `TMS_SYM_M2 : `TMS_SYM_P2;
      sy(1'h0);
      chk({s4, timing_leader}, {p, p, p, p, ld});
    end
  end
  endtask
  task test_done;
  begin
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  // ==========================================
  // stimulus
  always #5 ref_clk = ~ref_clk;
  initial
  begin
    #100000;
    fail_count = fail_count + 1;
    test_done;
  end
  initial
  begin
    {ref_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h0;
    {s_axi_wdata, strap_test_mode, fail_count, checks} = 0;
    s_axi_wstrb = 4'hF;
    cfg_leader = 1'h1;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    rd(`TMS_CTRL_OFS);
    chk(rv, `TMS_CTRL_RST);
    rd(`TMS_SCR_OFS);
    chk(rv, {21'h0, `TMS_SCR_RST});
    rd(4'hC);
    chk({rr, rv}, {`TMS_RESP_ERR, 32'h0});
    wr(4'hC, 32'h0);
    chk(br, `TMS_RESP_ERR);
    sy(1'h0);
    chk({s4, timing_leader}, {12'h2BE, 1'h1});
    cfg_leader <= 1'h0;
    sy(1'h0);
    sy(1'h0);
    chk(timing_leader, 1'h0);
    wr(`TMS_CTRL_OFS, 32'h1);
    chk(br, `TMS_RESP_OK);
    sy(1'h0);
    q = tx_symbol_clock;
    sy(1'h0);
    chk(tx_symbol_clock, !q);
    s_axi_wstrb <= 4'h2;
    wr(`TMS_CTRL_OFS, 32'hFFFFFFFF);
    s_axi_wstrb <= 4'hF;
    rd(`TMS_CTRL_OFS);
    chk(rv, 32'hFF01);
    sy(1'h0);
    sy(1'h0);
    chk(s4, 12'h2BE);
    wr(`TMS_CTRL_OFS, 32'h4000);
    alt(1'h1);
    wr(`TMS_CTRL_OFS, 32'h6000);
    alt(1'h0);
    chk(tx_symbol_clock, 1'h0);
    rd(`TMS_SCR_OFS);
    chk(rv, {21'h0, `TMS_SCR_RST});
    wr(`TMS_CTRL_OFS, 32'h2000);
    for (i = 0; i < 18; i = i + 1)
    begin
      sy(i == 0);
      chk({s4, timing_leader}, {{4{PAT[3*(i%16)+:3]}}, 1'h1});
    end
    wr(`TMS_CTRL_OFS, 32'h8000);
    sm = `TMS_SCR_RST;
    for (i = 0; i < 6; i = i + 1)
    begin
      sy(i == 0);
      e3 = {sm[2] ^ sm[8], sm[1] ^ sm[4], sm[0]};
      e3 = (e3 == 3'h1) ? `TMS_SYM_P1 : (e3 == 3'h2) ? `TMS_SYM_P2 :
           (e3 == 3'h3) ? `TMS_SYM_M1 : (e3 == 3'h4) ? `TMS_SYM_M2 :
           `TMS_SYM_Z;
      chk({s4, timing_leader}, {{4{e3}}, 1'h1});
      sm = {sm[9:0], ^(sm & 11'h500)};
    end
    rd(`TMS_SCR_OFS);
    chk(rv === {21'h0, `TMS_SCR_RST}, 1'h0);
    wr(`TMS_CTRL_OFS, 32'h0);
    strap_test_mode <= `TMS_MODE_2;
    alt(1'h1);
    strap_test_mode <= `TMS_MODE_NORM;
    rst_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    rd(`TMS_CTRL_OFS);
    chk(rv, `TMS_CTRL_RST);
    test_done;
  end
endmodule

bind tms_symbol_gen tms_symbol_gen_assertions i_tms_symbol_gen_assertions
(
  .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .local_sym_tick(local_sym_tick), .recov_sym_tick(recov_sym_tick),
  .tx_sym_a(tx_sym_a), .tx_sym_b(tx_sym_b), .tx_sym_c(tx_sym_c),
  .tx_sym_d(tx_sym_d), .tx_sym_valid(tx_sym_valid),
  .timing_leader(timing_leader), .tx_symbol_clock(tx_symbol_clock)
);
